/* bench/spir_peer.sv */
// Purpose: Serial peer for the SPI block, slave by default, master on demand
// Assumes: Mode 0, MSB first, pins seen directly
// Notes:   Records bytes, frame length and the last serial clock level time
`timescale 1ns/10ps
module spir_peer
(
	// Clock and pins
	input  wire logic clk,
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic mosi,
	// Driven side
	output logic      miso,
	output logic      m_en,
	output logic      m_sclk,
	output logic      m_cs_n
);
	logic [7:0] reply;
	logic [7:0] sh;
	logic [7:0] got[$];
	int         nb;
	int         fb;
	int         lastf;
	int         hc;
	int         half;
	logic       ps;
	initial
	begin
		{miso, m_en, m_sclk, ps} = 4'h0;
		m_cs_n = 1'b1;
		{reply, sh} = 16'h0000;
		{nb, fb, lastf, hc, half} = '0;
	end
	always @(negedge cs_n) if (!m_en)
	begin
		nb = 0;
		fb = 0;
		miso = reply[7];
	end
	always @(posedge cs_n) if (!m_en) lastf = fb;
	always @(posedge sclk) if (!m_en && !cs_n)
	begin
		sh = {sh[6:0], mosi};
		nb++;
		if (nb == 8)
		begin
			got.push_back(sh);
			fb++;
			nb = 0;
			reply++;
		end
	end
	always @(negedge sclk) if (!m_en && !cs_n) miso = reply[7-nb];
	// Nothing holds the line while deselected, so it must not look stable;
	// toggled mid-cycle so it never races a select edge or a driven bit
	always @(negedge clk) if (!m_en && cs_n) miso = ~miso;
	always @(posedge clk)
	begin
		if (sclk !== ps)
		begin
			half <= hc;
			hc <= 1;
		end
		else
			hc <= hc + 1;
		ps <= sclk;
	end
	// Three clocks per level keeps within the slave sampling limit
	task automatic mx(input logic [7:0] v, input int n);
		m_en <= 1'b1;
		m_cs_n <= 1'b0;
		for (int i = 0; i < n; i++)
		begin
			miso <= v[7-i];
			repeat (3) @(posedge clk);
			m_sclk <= 1'b1;
			repeat (3) @(posedge clk);
			m_sclk <= 1'b0;
		end
		repeat (3) @(posedge clk);
		m_cs_n <= 1'b1;
		repeat (3) @(posedge clk);
		m_en <= 1'b0;
	endtask
endmodule

/* bench/testbench.sv */
// Purpose: Self-checking bench for the SPI data and rate block
// Assumes: Peer model on the serial pins, Avalon-MM master tasks
// Notes:   Random traffic from a fixed seed with boundary cases mixed in
`timescale 1ns/10ps
module testbench
	import spir_pkg::*;
;
	localparam logic [31:0] ADR [7] = '{SPIR_RX_OFF, SPIR_TX_OFF, SPIR_RATE_OFF,
		SPIR_CFG_OFF, SPIR_STAT_OFF, SPIR_MASK_OFF, 32'h40030000};
	logic        sys_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [31:0] avs_address = 32'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        irq;
	logic        sclk_out;
	logic        sclk_oe_n;
	logic        cs_n_out;
	logic        cs_n_oe_n;
	logic        sdo;
	logic        sdo_oe_n;
	logic        miso;
	logic        p_en;
	logic        p_sclk;
	logic        p_cs_n;
	wire logic   sclk_w;
	wire logic   cs_w;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          seed = 32'hf88f;
	logic [31:0] q;
	logic [7:0]  a;
	logic [7:0]  b;
	logic [7:0]  r;
	int          dv;
	// Idle levels assumed: clock pulled low, select pulled high
	assign sclk_w = !sclk_oe_n ? sclk_out : (p_en ? p_sclk : 1'b0);
	assign cs_w = !cs_n_oe_n ? cs_n_out : (p_en ? p_cs_n : 1'b1);
	always #4 sys_clk = ~sys_clk;
	spir_core uut (.sys_clk(sys_clk), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .sclk_in(sclk_w),
		.sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .cs_n_in(cs_w), .cs_n_out(cs_n_out),
		.cs_n_oe_n(cs_n_oe_n), .sdi(miso), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
	spir_peer p (.clk(sys_clk), .sclk(sclk_w), .cs_n(cs_w), .mosi(sdo), .miso(miso),
		.m_en(p_en), .m_sclk(p_sclk), .m_cs_n(p_cs_n));
	function automatic logic [15:0] exp_rx(input logic dma, input logic [7:0] v);
		return dma ? {v + 8'h01, v} : {8'h00, v};
	endfunction
	function automatic logic [7:0] exp_res(input logic keep, input logic [7:0] x,
		input logic [7:0] y);
		return keep ? {x[7:5], y[7:3]} : y;
	endfunction
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic fail_out;
		error_cnt++;
		$display("mismatch at %0t: wait ran out", $time);
		report_and_stop();
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d,
		input logic [3:0] be);
		int i;
		avs_address <= ad;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		i = 0;
		do
		begin
			@(posedge sys_clk);
			i++;
		end
		while (avs_waitrequest !== 1'b0 && i < 50);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
		if (i == 50)
			fail_out();
	endtask
	task automatic wr(input logic [31:0] ad, input logic [31:0] d, input logic [3:0] be);
		bus(1'b1, ad, d, be);
	endtask
	task automatic rd(input logic [31:0] ad);
		bus(1'b0, ad, 32'h0, 4'hF);
	endtask
	// Waits for n bytes at the peer and the select released again
	task automatic wt(input int n);
		int i;
		i = 0;
		while ((p.got.size() < n || cs_w !== 1'b1) && i < 4000)
		begin
			@(posedge sys_clk);
			i++;
		end
		if (i == 4000)
			fail_out();
		repeat (4) @(posedge sys_clk);
	endtask
	initial
	begin
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		foreach (ADR[i])
		begin
			rd(ADR[i]);
			chk(q[15:0], 16'h0000);
		end
		wr(SPIR_RATE_OFF, 32'h0000FFFF, 4'hF);
		rd(SPIR_RATE_OFF);
		chk(q[15:0], 16'h01FF);
		wr(32'h40030000, 32'h0000FFFF, 4'hF);
		rd(32'h40030000);
		chk(q[15:0], 16'h0000);
		$display("test 1 done");
		// Single transfers as master; the divider ends are forced
		for (int k = 0; k < 6; k++)
		begin
			dv = (k == 0) ? 0 : (k == 5) ? 63 : ($random(seed) & 7);
			r = $random(seed);
			a = $random(seed);
			b = $random(seed);
			p.reply = r;
			wr(SPIR_RATE_OFF, {25'h0, k[0], dv[5:0]}, 4'hF);
			wr(SPIR_CFG_OFF, 32'h00000003, 4'hF);
			wr(SPIR_TX_OFF, {16'h0, b, a}, 4'h3);
			wt(1);
			chk({8'h00, p.got.pop_front()}, {8'h00, a});
			chk(16'(p.got.size()), 16'h0000);
			chk(16'(p.half), 16'(dv + 1));
			chk({13'h0, sclk_oe_n, cs_n_oe_n, sdo_oe_n}, 16'h0000);
			rd(SPIR_RX_OFF);
			chk(q[15:0], exp_rx(1'b0, r));
		end
		$display("test 2 done");
		// Half-word burst; edge interrupt on, then enable off, then high speed off
		wr(SPIR_MASK_OFF, 32'h00000003, 4'hF);
		for (int k = 0; k < 3; k++)
		begin
			r = $random(seed);
			a = $random(seed);
			b = $random(seed);
			p.reply = r;
			wr(SPIR_RATE_OFF, (k == 1) ? 32'h00000001 : 32'h00000101, 4'hF);
			wr(SPIR_CFG_OFF, (k == 2) ? 32'h00000807 : 32'h0000080F, 4'hF);
			wr(SPIR_TX_OFF, {16'h0, b, a}, 4'h3);
			wt(2);
			chk({8'h00, p.got.pop_front()}, {8'h00, a});
			chk({8'h00, p.got.pop_front()}, {8'h00, b});
			chk(16'(p.lastf), 16'h0002);
			chk({15'h0, irq}, {15'h0, k == 0});
			rd(SPIR_STAT_OFF);
			chk({14'h0, q[1:0]}, (k == 0) ? 16'h0003 : 16'h0000);
			rd(SPIR_RX_OFF);
			chk(q[15:0], exp_rx(1'b1, r));
			chk({15'h0, irq}, 16'h0000);
		end
		$display("test 3 done");
		// Slave aborted by the peer, with and without counter reset
		for (int k = 0; k < 2; k++)
		begin
			a = $random(seed);
			b = $random(seed);
			wr(SPIR_CFG_OFF, 32'h0, 4'hF);
			wr(SPIR_MASK_OFF, (k == 0) ? 32'h00000004 : 32'h0, 4'hF);
			wr(SPIR_RATE_OFF, {24'h0, ~k[0], 7'h0}, 4'hF);
			wr(SPIR_CFG_OFF, 32'h00000001, 4'hF);
			p.mx(a, 3);
			repeat (2) @(posedge sys_clk);
			chk({15'h0, irq}, {15'h0, k == 0});
			chk({13'h0, sclk_oe_n, cs_n_oe_n, sdo_oe_n}, 16'h0007);
			rd(SPIR_STAT_OFF);
			chk({15'h0, q[2]}, 16'h0001);
			// With counter reset the port is disabled after the error, else it stays on
			wr(SPIR_CFG_OFF, {31'h0, k[0]}, 4'hF);
			wr(SPIR_CFG_OFF, 32'h00000001, 4'hF);
			p.mx(b, (k == 0) ? 8 : 5);
			rd(SPIR_RX_OFF);
			chk(q[15:0], {8'h00, exp_res(k[0], a, b)});
			rd(SPIR_STAT_OFF);
			chk({15'h0, q[2]}, 16'h0000);
		end
		$display("test 4 done");
		report_and_stop();
	end
endmodule

/* pkg/spir_pkg.sv */
// Purpose: Shared constants for the SPI data and rate register block
// Assumes: 32-bit Avalon-MM byte addresses, one word per register
// Notes:   Status and mask layout are shared by the interrupt logic
package spir_pkg;
	// Register byte addresses
	localparam logic [31:0] SPIR_RX_OFF   = 32'h40030004;
	localparam logic [31:0] SPIR_TX_OFF   = 32'h40030008;
	localparam logic [31:0] SPIR_RATE_OFF = 32'h4003000C;
	localparam logic [31:0] SPIR_CFG_OFF  = 32'h40030010;
	localparam logic [31:0] SPIR_STAT_OFF = 32'h40030014;
	localparam logic [31:0] SPIR_MASK_OFF = 32'h40030018;
	// Rate register fields
	localparam int          SPIR_DIV_LSB   = 0;
	localparam int          SPIR_DIV_W     = 6;
	localparam int          SPIR_HFM_BIT   = 6;
	localparam int          SPIR_BIT_COUNTER_RESET_ON_CS_ERROR_BIT = 7;
	localparam int          SPIR_CSIRQ_BIT = 8;
	localparam logic [15:0] SPIR_RATE_WMASK = 16'h01FF;
	localparam logic [15:0] SPIR_RATE_RST   = 16'h0000;
	// Configuration register fields
	localparam int          SPIR_EN_BIT     = 0;
	localparam int          SPIR_MASTER_BIT = 1;
	localparam int          SPIR_DMA_BIT    = 2;
	localparam int          SPIR_HS_BIT     = 3;
	localparam int          SPIR_BURST_BIT  = 11;
	localparam logic [15:0] SPIR_CFG_WMASK  = 16'h080F;
	localparam logic [15:0] SPIR_CFG_RST    = 16'h0000;
	// Status and mask fields
	localparam int          SPIR_ST_W      = 5;
	localparam int          SPIR_ST_CSFALL = 0;
	localparam int          SPIR_ST_CSRISE = 1;
	localparam int          SPIR_ST_CS_ABORT_ERROR_FLAG  = 2;
	localparam int          SPIR_ST_RXOF   = 3;
	localparam int          SPIR_ST_TXUR   = 4;
	localparam int          SPIR_ST_RXCNT_LSB = 8;
	localparam int          SPIR_ST_TXCNT_LSB = 12;
	localparam logic [SPIR_ST_W-1:0] SPIR_MASK_RST = 5'h00;
	// Sizes and timing
	localparam int          SPIR_FIFO_DEPTH = 4;
	localparam int          SPIR_BYTE_LAST  = 7;
	typedef enum logic [1:0] {
		SPIR_M_IDLE,
		SPIR_M_SHIFT,
		SPIR_M_GAP
	} spir_mstate_e;
endpackage

/* verilog/spir_core.sv */
// Purpose: SPI data, rate and serial engine behind an Avalon-MM slave
// Assumes: Pins are synchronous to sys_clk; mode 0 framing, MSB first
// Notes:   Pin inputs are sampled directly, without a synchroniser
// Function
// - A receive read gives the oldest byte low and, with DMA, a second byte high.
// - A transmit write queues the low byte and, with DMA, the high byte next.
// - Without DMA the upper byte lane of receive and transmit reads as zero.
// - With the edge enable, burst and high-speed mode every chip-select edge sets its flag.
// - With the edge enable clear no chip-select edge flag or interrupt arises.
// - The edge enable acts only in burst transfer combined with high-speed mode.
// - With counter reset set a chip-select error clears the bit counter.
// - With counter reset clear the bit counter holds and resumes on reselect.
// - High-frequency mode samples receive data on the pad clock edge.
// - The serial clock is the bus clock divided by 2 x (rate factor + 1).
// - Deselect before a full byte raises the abort error flag.
// - A burst master keeps chip select low while transmit data remains.
`timescale 1ns/10ps
module spir_core
	import spir_pkg::*;
#(
	parameter int FIFO_DEPTH = SPIR_FIFO_DEPTH
)
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// Avalon-MM slave
	input  wire logic [31:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Interrupt
	output logic             irq,
	// Serial clock pin
	input  wire logic        sclk_in,
	output logic             sclk_out,
	output logic             sclk_oe_n,
	// Chip select pin, active low
	input  wire logic        cs_n_in,
	output logic             cs_n_out,
	output logic             cs_n_oe_n,
	// Serial data
	input  wire logic        sdi,
	output logic             sdo,
	output logic             sdo_oe_n
);
	localparam int CW = $clog2(FIFO_DEPTH + 1);

	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 15)
	begin : g_chk
		$error("spir_core FIFO_DEPTH must lie in 2..15");
	end

	function automatic logic [15:0] be_merge(input logic [15:0] old_v,
		input logic [31:0] wd, input logic [3:0] be, input logic [15:0] wmask);
		logic [15:0] v;
		v = old_v;
		if (be[0])
			v[7:0] = wd[7:0];
		if (be[1])
			v[15:8] = wd[15:8];
		return v & wmask;
	endfunction

	logic [15:0]          rate_r;
	logic [15:0]          cfg_r;
	logic [SPIR_ST_W-1:0] status_r;
	logic [SPIR_ST_W-1:0] mask_r;
	logic [SPIR_ST_W-1:0] st_set;
	logic [SPIR_ST_W-1:0] st_cap_r;
	logic [1:0]           rx_pop_n_r;
	logic [31:0]          rd_val;
	logic                 req;
	logic                 acc;
	logic                 en;
	logic                 master;
	logic                 dma;
	logic                 hs;
	logic                 burst;
	logic                 high_frequency_receive_clocking;
	logic                 bit_counter_reset_on_cs_error;
	logic                 csirq;
	logic [5:0]           div;

	logic                 sclk_d_r;
	logic                 cs_d_r;
	logic                 sclk_rise;
	logic                 sclk_fall;
	logic                 cs_fall;
	logic                 cs_rise;
	logic                 cs_act;

	logic [5:0]           div_cnt_r;
	logic                 tick;
	spir_mstate_e         mstate_r;
	logic                 phase_r;
	logic [2:0]           m_cnt_r;
	logic [2:0]           bit_cnt_r;
	logic [7:0]           rx_shift_r;
	logic [7:0]           tx_shift_r;

	logic                 m_pop;
	logic                 m_sh;
	logic                 s_ld;
	logic                 s_sh;
	logic                 eng_ld;
	logic [7:0]           ld_byte;
	logic                 rx_smp;
	logic                 rx_done;
	logic                 cs_err_evt;
	logic                 csedge_on;

	logic [1:0]           tx_push_n;
	logic [1:0]           tx_need;
	logic [1:0]           rx_pop_n;
	logic [1:0]           rx_push_n;
	logic [15:0]          tx_head;
	logic [15:0]          rx_head;
	logic [CW-1:0]        tx_cnt;
	logic [CW-1:0]        rx_cnt;

	assign en     = cfg_r[SPIR_EN_BIT];
	assign master = cfg_r[SPIR_MASTER_BIT];
	assign dma    = cfg_r[SPIR_DMA_BIT];
	assign hs     = cfg_r[SPIR_HS_BIT];
	assign burst  = cfg_r[SPIR_BURST_BIT];
	assign high_frequency_receive_clocking    = rate_r[SPIR_HFM_BIT];
	assign bit_counter_reset_on_cs_error  = rate_r[SPIR_BIT_COUNTER_RESET_ON_CS_ERROR_BIT];
	assign csirq  = rate_r[SPIR_CSIRQ_BIT];
	assign div    = rate_r[SPIR_DIV_LSB +: SPIR_DIV_W];

	// Pin edges
	assign sclk_rise = sclk_in & ~sclk_d_r;
	assign sclk_fall = ~sclk_in & sclk_d_r;
	assign cs_fall   = ~cs_n_in & cs_d_r;
	assign cs_rise   = cs_n_in & ~cs_d_r;
	assign cs_act    = ~cs_n_in;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_d_r <= 1'b0;
			cs_d_r   <= 1'b1;
		end
		else
		begin
			sclk_d_r <= sclk_in;
			cs_d_r   <= cs_n_in;
		end
	end

	// Avalon slave: waitrequest drops one cycle after the request appears
	assign req = avs_read | avs_write;
	assign acc = req & ~avs_waitrequest;

	always_comb
	begin
		rd_val = 32'h00000000;
		case (avs_address)
			SPIR_RX_OFF:
			begin
				if (rx_cnt != '0)
					rd_val[7:0] = rx_head[7:0];
				if (dma && rx_cnt > CW'(1))
					rd_val[15:8] = rx_head[15:8];
			end
			SPIR_RATE_OFF: rd_val[15:0] = rate_r;
			SPIR_CFG_OFF:  rd_val[15:0] = cfg_r;
			SPIR_STAT_OFF:
			begin
				rd_val[SPIR_ST_W-1:0] = status_r;
				rd_val[SPIR_ST_RXCNT_LSB +: CW] = rx_cnt;
				rd_val[SPIR_ST_TXCNT_LSB +: CW] = tx_cnt;
			end
			SPIR_MASK_OFF: rd_val[SPIR_ST_W-1:0] = mask_r;
			default:       rd_val = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
			st_cap_r        <= '0;
			rx_pop_n_r      <= 2'h0;
		end
		else
		begin
			avs_waitrequest <= ~(req & avs_waitrequest);
			if (avs_read && avs_waitrequest)
			begin
				avs_readdata <= rd_val;
				st_cap_r     <= (avs_address == SPIR_STAT_OFF) ? status_r : '0;
				if (rx_cnt == '0)
					rx_pop_n_r <= 2'h0;
				else if (dma && rx_cnt > CW'(1))
					rx_pop_n_r <= 2'h2;
				else
					rx_pop_n_r <= 2'h1;
			end
		end
	end

	// Register writes land at the accepting edge
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rate_r <= SPIR_RATE_RST;
			cfg_r  <= SPIR_CFG_RST;
			mask_r <= SPIR_MASK_RST;
		end
		else if (acc && avs_write)
		begin
			if (avs_address == SPIR_RATE_OFF)
				rate_r <= be_merge(rate_r, avs_writedata, avs_byteenable, SPIR_RATE_WMASK);
			if (avs_address == SPIR_CFG_OFF)
				cfg_r <= be_merge(cfg_r, avs_writedata, avs_byteenable, SPIR_CFG_WMASK);
			if (avs_address == SPIR_MASK_OFF)
				mask_r <= avs_writedata[SPIR_ST_W-1:0];
		end
	end

	// A write that does not fit is dropped whole rather than split
	assign tx_need   = (dma && avs_byteenable[1]) ? 2'h2 : 2'h1;
	assign tx_push_n = (acc && avs_write && avs_address == SPIR_TX_OFF && avs_byteenable[0]
		&& int'(tx_need) <= FIFO_DEPTH - int'(tx_cnt)) ? tx_need : 2'h0;
	assign rx_pop_n  = (acc && avs_read && avs_address == SPIR_RX_OFF) ? rx_pop_n_r : 2'h0;

	spir_fifo #(
		.DEPTH (FIFO_DEPTH),
		.CW    (CW)
	) u_tx_fifo (
		.clk       (sys_clk),
		.arst_n    (arst_n),
		.push_n    (tx_push_n),
		.push_data (avs_writedata[15:0]),
		.pop_n     ({1'b0, m_pop | (s_ld & (tx_cnt != '0))}),
		.head      (tx_head),
		.count     (tx_cnt)
	);

	spir_fifo #(
		.DEPTH (FIFO_DEPTH),
		.CW    (CW)
	) u_rx_fifo (
		.clk       (sys_clk),
		.arst_n    (arst_n),
		.push_n    (rx_push_n),
		.push_data ({8'h00, rx_shift_r[6:0], sdi}),
		.pop_n     (rx_pop_n),
		.head      (rx_head),
		.count     (rx_cnt)
	);

	// Half-period divider, reloaded from the factor
	assign tick = en && master && mstate_r != SPIR_M_IDLE && div_cnt_r == 6'h00;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			div_cnt_r <= 6'h00;
		else if (!tick && mstate_r != SPIR_M_IDLE && en && master)
			div_cnt_r <= div_cnt_r - 6'h01;
		else
			div_cnt_r <= div;
	end

	// Master sequencing
	assign m_pop = en && master && tx_cnt != '0 && ((mstate_r == SPIR_M_IDLE)
		|| (mstate_r == SPIR_M_SHIFT && tick && phase_r && m_cnt_r == 3'(SPIR_BYTE_LAST)
		&& burst));
	assign m_sh  = mstate_r == SPIR_M_SHIFT && tick && phase_r
		&& m_cnt_r != 3'(SPIR_BYTE_LAST);

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mstate_r <= SPIR_M_IDLE;
			phase_r  <= 1'b0;
			m_cnt_r  <= 3'h0;
			sclk_out <= 1'b0;
			cs_n_out <= 1'b1;
		end
		else if (!en || !master)
		begin
			mstate_r <= SPIR_M_IDLE;
			phase_r  <= 1'b0;
			m_cnt_r  <= 3'h0;
			sclk_out <= 1'b0;
			cs_n_out <= 1'b1;
		end
		else
		begin
			case (mstate_r)
				SPIR_M_IDLE:
				begin
					phase_r <= 1'b0;
					m_cnt_r <= 3'h0;
					if (m_pop)
					begin
						cs_n_out <= 1'b0;
						mstate_r <= SPIR_M_SHIFT;
					end
				end
				SPIR_M_SHIFT:
				begin
					if (tick)
					begin
						phase_r  <= ~phase_r;
						sclk_out <= ~phase_r;
						if (phase_r)
						begin
							m_cnt_r <= m_cnt_r + 3'h1;
							if (m_cnt_r == 3'(SPIR_BYTE_LAST) && !m_pop)
							begin
								cs_n_out <= 1'b1;
								mstate_r <= SPIR_M_GAP;
							end
						end
					end
				end
				SPIR_M_GAP:
				begin
					// One idle serial clock between separate frames
					if (tick)
					begin
						phase_r <= ~phase_r;
						if (phase_r)
							mstate_r <= SPIR_M_IDLE;
					end
				end
				default: mstate_r <= SPIR_M_IDLE;
			endcase
		end
	end

	// Slave loads on select and after each byte; the reload sits right after
	// the last rising edge, so the peer must not sample before its next rise
	assign s_ld   = en && !master && ((cs_fall && bit_cnt_r == 3'h0) || (rx_done && cs_act));
	assign s_sh   = en && !master && cs_act && sclk_fall;
	assign eng_ld = m_pop || s_ld;
	assign ld_byte = (tx_cnt != '0) ? tx_head[7:0] : 8'h00;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			tx_shift_r <= 8'h00;
			sdo        <= 1'b0;
		end
		else if (eng_ld)
		begin
			sdo        <= ld_byte[7];
			tx_shift_r <= {ld_byte[6:0], 1'b0};
		end
		else if (m_sh || s_sh)
		begin
			sdo        <= tx_shift_r[7];
			tx_shift_r <= {tx_shift_r[6:0], 1'b0};
		end
	end

	// Receive side; HIGH_FREQUENCY_RECEIVE_CLOCKING uses the pad clock edge, immune to internal timing skew
	assign rx_smp = en && (master ? (high_frequency_receive_clocking ? sclk_rise
		: (mstate_r == SPIR_M_SHIFT && tick && !phase_r))
		: (cs_act && sclk_rise));
	assign rx_done    = rx_smp && bit_cnt_r == 3'(SPIR_BYTE_LAST);
	assign rx_push_n  = (rx_done && int'(rx_cnt) < FIFO_DEPTH) ? 2'h1 : 2'h0;
	assign cs_err_evt = en && !master && cs_rise && bit_cnt_r != 3'h0;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bit_cnt_r  <= 3'h0;
			rx_shift_r <= 8'h00;
		end
		else if (!en)
			bit_cnt_r <= 3'h0;
		else if (cs_err_evt && bit_counter_reset_on_cs_error)
			bit_cnt_r <= 3'h0;
		else if (rx_smp)
		begin
			// Without counter reset, a broken byte resumes at reselect
			bit_cnt_r  <= bit_cnt_r + 3'h1;
			rx_shift_r <= {rx_shift_r[6:0], sdi};
		end
	end

	// Sticky status: a set in the clearing cycle survives
	assign csedge_on = en && csirq && burst && hs;

	always_comb
	begin
		st_set = '0;
		st_set[SPIR_ST_CSFALL] = csedge_on && cs_fall;
		st_set[SPIR_ST_CSRISE] = csedge_on && cs_rise;
		st_set[SPIR_ST_CS_ABORT_ERROR_FLAG]  = cs_err_evt;
		st_set[SPIR_ST_RXOF]   = rx_done && int'(rx_cnt) >= FIFO_DEPTH;
		st_set[SPIR_ST_TXUR]   = s_ld && tx_cnt == '0;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			status_r <= '0;
			irq      <= 1'b0;
		end
		else
		begin
			status_r <= (status_r & ~((acc && avs_read) ? st_cap_r : '0)) | st_set;
			irq      <= |(status_r & mask_r);
		end
	end

	// Pin drivers
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_oe_n <= 1'b1;
			cs_n_oe_n <= 1'b1;
			sdo_oe_n  <= 1'b1;
		end
		else
		begin
			sclk_oe_n <= ~(en & master);
			cs_n_oe_n <= ~(en & master);
			sdo_oe_n  <= ~(en & (master | cs_act));
		end
	end

	a_rx_upper_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
		acc && avs_read && avs_address == SPIR_RX_OFF && !$past(dma)
		|-> avs_readdata[15:8] == 8'h00)
		else $error("upper receive lane not zero without DMA");

	a_cs_fall_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
		csedge_on && cs_fall |=> status_r[SPIR_ST_CSFALL] ##1 irq || !mask_r[SPIR_ST_CSFALL])
		else $error("chip-select fall did not flag");

	a_cs_edge_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$rose(status_r[SPIR_ST_CSRISE]) |-> $past(csirq))
		else $error("edge flag without edge enable");

	a_cs_edge_mode: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$rose(status_r[SPIR_ST_CSFALL]) |-> $past(burst && hs))
		else $error("edge flag outside burst high-speed mode");

	a_cnt_reset: assert property (@(posedge sys_clk) disable iff (!arst_n)
		cs_err_evt && bit_counter_reset_on_cs_error |=> bit_cnt_r == 3'h0)
		else $error("bit counter not cleared on abort");

	a_cnt_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		cs_err_evt && !bit_counter_reset_on_cs_error && !rx_smp |=> bit_cnt_r == $past(bit_cnt_r) && bit_cnt_r != 3'h0)
		else $error("bit counter lost on abort");

	a_cs_abort_error_flag_flag: assert property (@(posedge sys_clk) disable iff (!arst_n)
		cs_n_in && !$past(cs_n_in) && en && !master && bit_cnt_r != 3'h0
		|=> status_r[SPIR_ST_CS_ABORT_ERROR_FLAG])
		else $error("abort error not flagged");

	a_div_period: assert property (@(posedge sys_clk) disable iff (!arst_n)
		tick |=> div_cnt_r == $past(div))
		else $error("divider not reloaded from factor");

	a_burst_cs_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		mstate_r == SPIR_M_SHIFT && tick && phase_r && m_cnt_r == 3'h7 && burst
		&& tx_cnt != '0 && en && master |=> !cs_n_out ##1 !cs_n_out)
		else $error("burst chip select released with data queued");
endmodule

/* verilog/spir_fifo.sv */
// Purpose: Byte FIFO taking and giving up to two bytes per cycle
// Assumes: Caller never pops more than held nor pushes beyond space
// Notes:   Shift-register form; entry 0 is always the oldest byte
`timescale 1ns/10ps
module spir_fifo
	import spir_pkg::*;
#(
	parameter int DEPTH = SPIR_FIFO_DEPTH,
	parameter int CW    = $clog2(DEPTH + 1)
)
(
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          arst_n,
	// Fill side
	input  wire logic [1:0]    push_n,
	input  wire logic [15:0]   push_data,
	// Drain side
	input  wire logic [1:0]    pop_n,
	output logic      [15:0]   head,
	output logic      [CW-1:0] count
);
	logic [7:0]    mem_r   [DEPTH];
	logic [7:0]    mem_nxt [DEPTH];
	logic [CW-1:0] count_r;
	int            base;

	if (DEPTH < 2 || DEPTH > 15)
	begin : g_chk
		$error("spir_fifo DEPTH must lie in 2..15");
	end

	always_comb
	begin
		base = int'(count_r) - int'(pop_n);
		for (int i = 0; i < DEPTH; i++)
		begin
			if (i + int'(pop_n) < DEPTH)
				mem_nxt[i] = mem_r[i + int'(pop_n)];
			else
				mem_nxt[i] = 8'h00;
			if (push_n != 2'h0 && i == base)
				mem_nxt[i] = push_data[7:0];
			if (push_n == 2'h2 && i == base + 1)
				mem_nxt[i] = push_data[15:8];
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count_r <= '0;
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= 8'h00;
		end
		else
		begin
			count_r <= CW'(int'(count_r) - int'(pop_n) + int'(push_n));
			mem_r   <= mem_nxt;
		end
	end

	assign head  = {mem_r[1], mem_r[0]};
	assign count = count_r;
endmodule
